// ===== clock_gen_pkg.sv
// Constants, register layouts and mode codes of the clock generator.
// Assumes a 200 MHz system clock and 32-bit AXI4-Lite register access.
package clock_gen_pkg;
   localparam int CLK_KHZ        = 200000;
   localparam int INT_REF_KHZ    = 32;
   localparam int T_IREFST_US    = 100;
   localparam int F_LOC_LOW_KHZ  = 25;
   localparam int F_LOC_HIGH_KHZ = 500;
   localparam int LOC_HIGH_CYC   = CLK_KHZ / F_LOC_HIGH_KHZ;
   localparam int OSC_INIT_EDGES = 1024;
   localparam int LOCK_TICKS     = 16;
   localparam int LOCK_TOL       = 2;
   localparam int FLL_MULT       = 1024;
   localparam int VCO_STEP_SHIFT = 2;
   localparam int BUS_RATIO      = 2;

   localparam logic [7:0] OFS_CTRL_ONE   = 8'h00;
   localparam logic [7:0] OFS_CTRL_TWO   = 8'h04;
   localparam logic [7:0] OFS_CTRL_THREE = 8'h08;
   localparam logic [7:0] OFS_STATUS     = 8'h0c;
   localparam logic [7:0] OFS_TRIM       = 8'h10;
   localparam logic [7:0] OFS_RST_STATUS = 8'h14;
   localparam int         LOC_BIT        = 2;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   localparam logic [1:0] CLOCK_SELECT_LOOP = 2'h0;
   localparam logic [1:0] CLOCK_SELECT_INT  = 2'h1;
   localparam logic [1:0] CLOCK_SELECT_EXT  = 2'h2;
   localparam logic [1:0] CLOCK_SELECT_STATUS_PLL = 2'h3;
   localparam logic [1:0] BUS_DIVIDER_ONE  = 2'h0;
   localparam logic [1:0] BUS_DIVIDER_TWO  = 2'h1;
   localparam logic [2:0] FF_MIN_REFERENCE_DIVIDER_ONE = 3'h2;
   localparam logic [2:0] FF_MIN_REFERENCE_DIVIDER_TWO = 3'h3;

   typedef struct packed {
      logic [1:0] clock_select;
      logic [2:0] reference_divider;
      logic       internal_ref_select;
      logic       int_ref_out_enable;
      logic       int_ref_stop_enable;
   } ctrl_one_t;

   typedef struct packed {
      logic [1:0] bus_divider;
      logic       range_high;
      logic       high_gain;
      logic       low_power;
      logic       crystal_select;
      logic       ext_ref_out_enable;
      logic       ext_ref_stop_enable;
   } ctrl_two_t;

   typedef struct packed {
      logic       spare_hi;
      logic       pll_select;
      logic       clock_monitor_enable;
      logic       spare_lo;
      logic [3:0] vco_multiplier;
   } ctrl_three_t;

   typedef struct packed {
      logic       spare;
      logic       lock;
      logic       pll_select_status;
      logic       internal_ref_status;
      logic [1:0] clock_select_status;
      logic       oscillator_ready_flag;
      logic       fine_trim_bit;
   } status_t;

   localparam ctrl_one_t   CTRL_ONE_RST   = 8'h04;
   localparam ctrl_two_t   CTRL_TWO_RST   = 8'h40;
   localparam ctrl_three_t CTRL_THREE_RST = 8'h01;
   localparam status_t     STATUS_RST     = 8'h10;
   localparam logic [7:0]  TRIM_RST       = 8'h80;

   typedef enum logic [2:0] {
      fll_engaged_internal,
      fll_engaged_external,
      fll_bypassed_internal,
      fll_bypassed_external,
      pll_engaged_external,
      pll_bypassed_external,
      low_power_internal_bypass,
      low_power_external_bypass
   } mode_t;
endpackage

// ===== pulse_divider.sv
// Divides a stream of one-cycle enable pulses by a run-time ratio.
// Assumes tick_in and ratio are synchronous to aclk.
module pulse_divider
   import clock_gen_pkg::*;
#(
   parameter int W = 16
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         tick_in,
   input  wire logic [W-1:0] ratio,
   output logic              tick_out
);
   typedef struct packed {
      logic [W-1:0] cnt;
   } div_state_t;

   div_state_t s_r;
   div_state_t s_nxt;
   logic       last;

   // Ratio of zero behaves as one
   assign last     = ((s_r.cnt + W'(1)) >= ratio);
   assign tick_out = tick_in & last;

   always_comb begin
      s_nxt = s_r;
      if (!aresetn) begin
         s_nxt.cnt = '0;
      end else if (tick_in) begin
         s_nxt.cnt = last ? '0 : s_r.cnt + W'(1);
      end
   end

   always_ff @(posedge aclk) begin
      s_r <= s_nxt;
   end
endmodule

// ===== clock_gen.sv
// Clock generator core: references, loop model, mode switch, registers.
// Assumes synchronous inputs and an AXI4-Lite master on aclk.
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
module clock_gen
   import clock_gen_pkg::*;
#(
   parameter int CNT_W       = 16,
   parameter int IREFST_CYC  = (T_IREFST_US * CLK_KHZ + 999) / 1000,
   parameter int INT_REF_DIV = CLK_KHZ / INT_REF_KHZ,
   parameter int LOC_LOW_CYC = CLK_KHZ / F_LOC_LOW_KHZ
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        power_on_resetn,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic        ext_ref_in,
   input  wire logic        stop_request,
   output logic             ext_osc_enable,
   output logic             ext_ref_clock_out,
   output logic             int_ref_clock_out,
   output logic             fixed_freq_clock_out,
   output logic             fixed_freq_valid,
   output logic             generator_output_clock,
   output logic             bus_clock_out,
   output logic             loss_reset_request,
   output mode_t            current_mode
);
   typedef struct packed {
      ctrl_one_t        c1;
      ctrl_two_t        c2;
      ctrl_three_t      c3;
      status_t          st;
      logic [7:0]       trim;
      logic             loc_flag;
      logic             aw_got;
      logic [7:0]       aw_addr;
      logic             w_got;
      logic [7:0]       w_byte;
      logic             w_lane;
      logic             bvalid;
      logic [1:0]       bresp;
      logic             rvalid;
      logic [7:0]       rbyte;
      logic [1:0]       rresp;
      logic [CNT_W-1:0] irefst_cnt;
      logic             iref_stable;
      logic [CNT_W-1:0] osc_cnt;
      logic [CNT_W-1:0] loc_cnt;
      logic [CNT_W-1:0] per_cnt;
      logic [CNT_W-1:0] per_prev;
      logic [CNT_W:0]   acc;
      logic [7:0]       lock_cnt;
      logic             ext_prev;
      logic             ext_out;
      logic             int_out;
      logic             ff_out;
      logic             ff_ok;
      logic             gen_out;
      logic             bus_out;
      logic             loc_rst;
      mode_t            mode;
   } state_t;

   state_t           s_r;
   state_t           s_nxt;
   logic             run;
   logic             ext_tick;
   logic             ext_mode;
   logic             ext_want;
   logic             ext_run;
   logic             ext_ok;
   logic             int_on;
   logic             int_tick;
   logic             ref_src;
   logic             rtick;
   logic             low_power;
   logic             loop_on;
   logic [CNT_W:0]   mult;
   logic [CNT_W:0]   acc_sum;
   logic             loop_tick;
   logic             src_tick;
   logic             gen_tick;
   logic             bus_tick;
   logic [CNT_W-1:0] loc_limit;
   logic             per_stable;

   assign run      = ~stop_request;
   assign ext_tick = ext_ref_in & ~s_r.ext_prev;
   assign ext_mode = ~s_r.st.internal_ref_status
                   | (s_r.st.clock_select_status == CLOCK_SELECT_EXT);
   assign ext_want = s_r.c2.ext_ref_out_enable | ext_mode
                   | ~s_r.c1.internal_ref_select
                   | (s_r.c1.clock_select == CLOCK_SELECT_EXT);
   // In stop only the stop-enabled output or an external mode keeps it
   assign ext_run  = run ? ext_want
                   : ((s_r.c2.ext_ref_out_enable
                       & s_r.c2.ext_ref_stop_enable) | ext_mode);
   assign ext_ok   = ext_run & (~s_r.c2.crystal_select
                   | s_r.st.oscillator_ready_flag);
   assign int_on   = run | (s_r.c1.int_ref_out_enable
                   & s_r.c1.int_ref_stop_enable);
   // Loop reference never comes from outside while internal reference status is set
   assign ref_src  = s_r.st.internal_ref_status ? int_tick
                   : (ext_tick & ext_ok);
   assign low_power = s_r.c2.low_power
                    & ((s_r.st.clock_select_status == CLOCK_SELECT_INT)
                    | (s_r.st.clock_select_status == CLOCK_SELECT_EXT));
   // Loop keeps running while bypassed unless low power is asked
   assign loop_on  = run & s_r.iref_stable & ~low_power;
   assign mult     = s_r.st.pll_select_status
                   ? (CNT_W+1)'({s_r.c3.vco_multiplier, 2'b00})
                   : (CNT_W+1)'(FLL_MULT);
   assign acc_sum  = s_r.acc + mult;
   // Phase accumulator gives mult loop ticks per reference period
   assign loop_tick = loop_on & (s_r.per_prev != '0)
                    & (acc_sum >= {1'b0, s_r.per_prev});
   assign loc_limit = s_r.c2.range_high ? CNT_W'(LOC_HIGH_CYC)
                    : CNT_W'(LOC_LOW_CYC);
   assign per_stable =
      ({1'b0, s_r.per_cnt} <= ({1'b0, s_r.per_prev}
                               + (CNT_W+1)'(LOCK_TOL)))
      && (({1'b0, s_r.per_cnt} + (CNT_W+1)'(LOCK_TOL))
          >= {1'b0, s_r.per_prev});

   always_comb begin
      case (s_r.st.clock_select_status)
         CLOCK_SELECT_INT: src_tick = int_tick;
         CLOCK_SELECT_EXT: src_tick = ext_tick & ext_ok;
         default:  src_tick = loop_tick;
      endcase
   end

   pulse_divider #(.W(CNT_W)) u_int_div (
      .aclk     (aclk),
      .aresetn  (aresetn & power_on_resetn),
      .tick_in  (int_on),
      .ratio    (CNT_W'(INT_REF_DIV)),
      .tick_out (int_tick)
   );

   pulse_divider #(.W(CNT_W)) u_ref_div (
      .aclk     (aclk),
      .aresetn  (aresetn & power_on_resetn),
      .tick_in  (ref_src & run),
      .ratio    (CNT_W'(1) << s_r.c1.reference_divider),
      .tick_out (rtick)
   );

   pulse_divider #(.W(CNT_W)) u_gen_div (
      .aclk     (aclk),
      .aresetn  (aresetn & power_on_resetn),
      .tick_in  (src_tick & run),
      .ratio    (CNT_W'(1) << s_r.c2.bus_divider),
      .tick_out (gen_tick)
   );

   pulse_divider #(.W(CNT_W)) u_bus_div (
      .aclk     (aclk),
      .aresetn  (aresetn & power_on_resetn),
      .tick_in  (gen_tick),
      .ratio    (CNT_W'(BUS_RATIO)),
      .tick_out (bus_tick)
   );

   always_comb begin
      logic [1:0] tgt;
      logic       avail;
      logic       relock;
      logic [7:0] idx;
      tgt    = s_r.st.clock_select_status;
      avail  = 1'b0;
      relock = 1'b0;
      idx    = {s_r.aw_addr[7:2], 2'b00};
      s_nxt  = s_r;
      s_nxt.ext_prev = ext_ref_in;
      s_nxt.loc_rst  = 1'b0;

      // Register bus, write side
      if (awvalid && awready) begin
         s_nxt.aw_got  = 1'b1;
         s_nxt.aw_addr = awaddr;
      end
      if (wvalid && wready) begin
         s_nxt.w_got  = 1'b1;
         s_nxt.w_byte = wdata[7:0];
         s_nxt.w_lane = wstrb[0];
      end
      if (s_r.bvalid && bready) begin
         s_nxt.bvalid = 1'b0;
      end
      if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got  = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp  = RESP_OKAY;
         case (idx)
            OFS_CTRL_ONE: if (s_r.w_lane) s_nxt.c1 = s_r.w_byte;
            OFS_CTRL_TWO: if (s_r.w_lane) s_nxt.c2 = s_r.w_byte;
            OFS_CTRL_THREE: if (s_r.w_lane) s_nxt.c3 = s_r.w_byte;
            OFS_STATUS: begin
               if (s_r.w_lane) s_nxt.st.fine_trim_bit = s_r.w_byte[0];
            end
            OFS_TRIM: if (s_r.w_lane) s_nxt.trim = s_r.w_byte;
            OFS_RST_STATUS: begin
               if (s_r.w_lane && s_r.w_byte[LOC_BIT]) begin
                  s_nxt.loc_flag = 1'b0;
               end
            end
            default: s_nxt.bresp = RESP_DECERR;
         endcase
      end

      // Register bus, read side
      if (s_r.rvalid && rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (arvalid && arready) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp  = RESP_OKAY;
         case ({araddr[7:2], 2'b00})
            OFS_CTRL_ONE:   s_nxt.rbyte = s_r.c1;
            OFS_CTRL_TWO:   s_nxt.rbyte = s_r.c2;
            OFS_CTRL_THREE: s_nxt.rbyte = s_r.c3;
            OFS_STATUS:     s_nxt.rbyte = s_r.st;
            OFS_TRIM:       s_nxt.rbyte = s_r.trim;
            OFS_RST_STATUS: begin
               s_nxt.rbyte = 8'(s_r.loc_flag) << LOC_BIT;
            end
            default: begin
               s_nxt.rbyte = 8'h00;
               s_nxt.rresp = RESP_DECERR;
            end
         endcase
      end

      // Internal reference settling after reset
      if (!s_r.iref_stable) begin
         if (s_r.irefst_cnt >= CNT_W'(IREFST_CYC - 1)) begin
            s_nxt.iref_stable = 1'b1;
         end else begin
            s_nxt.irefst_cnt = s_r.irefst_cnt + CNT_W'(1);
         end
      end

      // Oscillator start-up count
      if (ext_run && s_r.c2.crystal_select) begin
         if (ext_tick && !s_r.st.oscillator_ready_flag) begin
            if (s_r.osc_cnt >= CNT_W'(OSC_INIT_EDGES - 1)) begin
               s_nxt.st.oscillator_ready_flag = 1'b1;
            end else begin
               s_nxt.osc_cnt = s_r.osc_cnt + CNT_W'(1);
            end
         end
      end else begin
         s_nxt.osc_cnt = '0;
         s_nxt.st.oscillator_ready_flag = 1'b0;
      end

      // Reference switch completes on a tick of the new reference
      if (s_r.c1.internal_ref_select != s_r.st.internal_ref_status) begin
         if (s_r.c1.internal_ref_select ? int_tick
                                         : (ext_tick & ext_ok)) begin
            s_nxt.st.internal_ref_status = s_r.c1.internal_ref_select;
            relock = 1'b1;
         end
      end

      // Loop select completes once the new loop gets a reference tick
      if ((s_r.c3.pll_select != s_r.st.pll_select_status) && rtick) begin
         s_nxt.st.pll_select_status = s_r.c3.pll_select;
         relock = 1'b1;
      end

      // Clock select, switched only to an available source
      case (s_r.c1.clock_select)
         CLOCK_SELECT_LOOP: begin
            tgt   = s_r.st.pll_select_status ? CLOCK_SELECT_STATUS_PLL
                                             : CLOCK_SELECT_LOOP;
            avail = s_r.st.lock & loop_tick
                  & (s_r.c3.pll_select
                     == s_r.st.pll_select_status);
         end
         CLOCK_SELECT_INT: begin
            tgt   = CLOCK_SELECT_INT;
            avail = int_tick;
         end
         CLOCK_SELECT_EXT: begin
            tgt   = CLOCK_SELECT_EXT;
            avail = ext_tick & ext_ok;
         end
         default: begin
            tgt   = s_r.st.clock_select_status;
            avail = 1'b0;
         end
      endcase
      if ((tgt != s_r.st.clock_select_status) && avail) begin
         s_nxt.st.clock_select_status = tgt;
      end

      // Loop model: period measurement, lock, frequency synthesis
      if (!loop_on || relock) begin
         s_nxt.per_cnt  = '0;
         s_nxt.per_prev = '0;
         s_nxt.acc      = '0;
         s_nxt.lock_cnt = 8'h00;
         s_nxt.st.lock  = 1'b0;
      end else begin
         if (s_r.per_cnt != '1) begin
            s_nxt.per_cnt = s_r.per_cnt + CNT_W'(1);
         end
         if (rtick) begin
            s_nxt.per_cnt  = '0;
            s_nxt.per_prev = s_r.per_cnt;
            if (per_stable && (s_r.per_prev != '0)) begin
               if (s_r.lock_cnt >= 8'(LOCK_TICKS - 1)) begin
                  s_nxt.st.lock = 1'b1;
               end else begin
                  s_nxt.lock_cnt = s_r.lock_cnt + 8'h01;
               end
            end else begin
               s_nxt.lock_cnt = 8'h00;
               s_nxt.st.lock  = 1'b0;
            end
         end
         if (s_r.per_prev != '0) begin
            s_nxt.acc = loop_tick ? acc_sum - {1'b0, s_r.per_prev}
                                  : acc_sum;
         end
      end

      // Clock monitor on the external reference
      if (s_r.c3.clock_monitor_enable && ext_run && run) begin
         if (ext_tick) begin
            s_nxt.loc_cnt = '0;
         end else if (s_r.loc_cnt < loc_limit) begin
            s_nxt.loc_cnt = s_r.loc_cnt + CNT_W'(1);
            if (s_r.loc_cnt == loc_limit - CNT_W'(1)) begin
               s_nxt.loc_rst  = 1'b1;
               s_nxt.loc_flag = 1'b1;
            end
         end
      end else begin
         s_nxt.loc_cnt = '0;
      end

      // Registered clock enables
      s_nxt.ext_out = ext_tick & ext_run
                    & s_r.c2.ext_ref_out_enable;
      s_nxt.int_out = int_tick & s_r.c1.int_ref_out_enable;
      s_nxt.ff_out  = rtick;
      s_nxt.gen_out = gen_tick;
      s_nxt.bus_out = bus_tick;
      s_nxt.ff_ok   = ~(low_power
                     | (s_r.st.clock_select_status == CLOCK_SELECT_INT)
                     | (s_r.st.clock_select_status == CLOCK_SELECT_EXT))
                    | ~(((s_r.c2.bus_divider == BUS_DIVIDER_ONE)
                         && (s_r.c1.reference_divider < FF_MIN_REFERENCE_DIVIDER_ONE))
                        || ((s_r.c2.bus_divider == BUS_DIVIDER_TWO)
                         && (s_r.c1.reference_divider
                             < FF_MIN_REFERENCE_DIVIDER_TWO)));

      case (s_r.st.clock_select_status)
         CLOCK_SELECT_LOOP: begin
            s_nxt.mode = s_r.st.internal_ref_status
                       ? fll_engaged_internal : fll_engaged_external;
         end
         CLOCK_SELECT_INT: begin
            s_nxt.mode = s_r.c2.low_power ? low_power_internal_bypass
                                          : fll_bypassed_internal;
         end
         CLOCK_SELECT_EXT: begin
            if (s_r.c2.low_power) begin
               s_nxt.mode = low_power_external_bypass;
            end else if (s_r.st.pll_select_status) begin
               s_nxt.mode = pll_bypassed_external;
            end else begin
               s_nxt.mode = fll_bypassed_external;
            end
         end
         default: s_nxt.mode = pll_engaged_external;
      endcase

      // Loss flag survives the reset it causes; set beats clear
      if (!power_on_resetn || !aresetn) begin
         s_nxt          = '0;
         s_nxt.c1       = CTRL_ONE_RST;
         s_nxt.c2       = CTRL_TWO_RST;
         s_nxt.c3       = CTRL_THREE_RST;
         s_nxt.st       = STATUS_RST;
         s_nxt.trim     = TRIM_RST;
         s_nxt.mode     = fll_engaged_internal;
         s_nxt.ext_prev = 1'b0;
         s_nxt.ff_ok    = 1'b1;
         if (power_on_resetn) begin
            s_nxt.loc_flag = s_r.loc_flag | s_r.loc_rst;
            s_nxt.trim     = s_r.trim;
            s_nxt.st.fine_trim_bit = s_r.st.fine_trim_bit;
         end
      end
   end

   always_ff @(posedge aclk) begin
      s_r <= s_nxt;
   end

   assign awready = ~s_r.aw_got & ~s_r.bvalid;
   assign wready  = ~s_r.w_got & ~s_r.bvalid;
   assign bvalid  = s_r.bvalid;
   assign bresp   = s_r.bresp;
   assign arready = ~s_r.rvalid;
   assign rvalid  = s_r.rvalid;
   assign rresp   = s_r.rresp;
   assign rdata   = {24'h000000, s_r.rbyte};

   assign ext_osc_enable         = ext_run;
   assign ext_ref_clock_out      = s_r.ext_out;
   assign int_ref_clock_out      = s_r.int_out;
   assign fixed_freq_clock_out   = s_r.ff_out;
   assign fixed_freq_valid       = s_r.ff_ok;
   assign generator_output_clock = s_r.gen_out;
   assign bus_clock_out          = s_r.bus_out;
   assign loss_reset_request     = s_r.loc_rst;
   assign current_mode           = s_r.mode;
endmodule

// ===== ext_ref_src.sv
// Behavioural external clock source feeding the reference input.
// Assumes en follows the generator's oscillator enable.
module ext_ref_src #(
   parameter int HALF = 5
) (
   input  wire logic aclk,
   input  wire logic en,
   input  wire logic dead,
   output logic      clk_o
);
   timeunit 1ns;
   timeprecision 100ps;
   int n = 0;
   initial clk_o = 1'b0;
   // Fixed rate inside the scaled range; stands low when off or dead
   always @(posedge aclk) begin
      n <= (n == HALF - 1) ? 0 : n + 1;
      if (!en || dead)
         clk_o <= 1'b0;
      else if (n == HALF - 1)
         clk_o <= !clk_o;
   end
endmodule

// ===== clock_gen_sva.sv
// Port-level assertions for the clock generator.
// Assumes one aclk domain and both resets active low.
module clock_gen_chk (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        power_on_resetn,
   input wire logic        ext_ref_in,
   input wire logic        stop_request,
   input wire logic        awready,
   input wire logic        wready,
   input wire logic [1:0]  bresp,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic        arready,
   input wire logic [31:0] rdata,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic        ext_ref_clock_out,
   input wire logic        generator_output_clock,
   input wire logic        bus_clock_out,
   input wire logic        loss_reset_request
);
   logic [1:0] gcnt_r;
   logic [1:0] gcnt_nxt;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn || !power_on_resetn);
   // Generator pulses seen since the last bus pulse
   always_comb gcnt_nxt = bus_clock_out ? 2'd0
                        : gcnt_r + 2'(generator_output_clock);
   always_ff @(posedge aclk)
      gcnt_r <= (!aresetn || !power_on_resetn) ? 2'd0 : gcnt_nxt;
   a_ext_pulse: assert property (ext_ref_clock_out |->
      $past(ext_ref_in) && !$past(ext_ref_in, 2)) else $error("ext pulse");
   a_loss_pulse: assert property (loss_reset_request |=>
      !loss_reset_request) else $error("loss pulse too long");
   a_bus_half: assert property (bus_clock_out |->
      gcnt_r + 2'(generator_output_clock) == 2'd2) else $error("bus ratio");
   a_bresp_hold: assert property (bvalid && !bready |=>
      bvalid && $stable(bresp)) else $error("write response dropped");
   a_rdata_hold: assert property (rvalid && !rready |=>
      rvalid && $stable(rdata)) else $error("read data dropped");
   a_read_busy: assert property (rvalid |-> !arready)
      else $error("read address taken while busy");
   a_write_busy: assert property (bvalid |-> !awready && !wready)
      else $error("write taken while busy");
   a_stop_gate: assert property (stop_request [*2] |->
      !generator_output_clock && !bus_clock_out) else $error("stop leak");
endmodule
bind clock_gen clock_gen_chk chk_u (.aclk, .aresetn, .power_on_resetn,
   .ext_ref_in, .stop_request, .awready, .wready, .bresp, .bvalid, .bready,
   .arready, .rdata, .rvalid, .rready, .ext_ref_clock_out,
   .generator_output_clock, .bus_clock_out, .loss_reset_request);

// ===== tb_top.sv
// Self-checking bench: registers, reference output, modes, clock monitor.
// Assumes a behavioural external source and scaled reference counts.
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import clock_gen_pkg::*;
   logic aclk = 0, aresetn = 0, power_on_resetn = 0, stop_request = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic dead = 0;
   logic [7:0] awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [3:0] wstrb = 4'h1;
   logic [1:0] bresp, rresp, s;
   logic awready, wready, bvalid, arready, rvalid, ext_ref_in;
   logic ext_osc_enable, ext_ref_clock_out, fixed_freq_valid;
   logic generator_output_clock, bus_clock_out, loss_reset_request;
   mode_t current_mode;
   int error_cnt = 0, cmp_count = 0, cyc = 0, e, p;
   clock_gen #(.IREFST_CYC(20), .INT_REF_DIV(8), .LOC_LOW_CYC(200)) dut_u (
      .aclk, .aresetn, .power_on_resetn, .awaddr, .awvalid, .awready,
      .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .ext_ref_in,
      .stop_request, .ext_osc_enable, .ext_ref_clock_out,
      .int_ref_clock_out(), .fixed_freq_clock_out(), .fixed_freq_valid,
      .generator_output_clock, .bus_clock_out, .loss_reset_request,
      .current_mode);
   ext_ref_src #(.HALF(5)) src_u (.aclk, .en(ext_osc_enable), .dead,
      .clk_o(ext_ref_in));
   always #2.5 aclk = ~aclk;
   task finish_test;
      if (error_cnt == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         error_cnt++;
         finish_test;
      end
   end
   task chk(input logic [31:0] g, input logic [31:0] x);
      cmp_count++;
      if (g !== x) begin
         error_cnt++;
         $display("mismatch t=%0t got %h exp %h", $time, g, x);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] v);
      logic ta, tw, b;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      b = 1'b0;
      while (awvalid || wvalid || !b) begin
         @(negedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         b = bvalid;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
      bready <= 1'b0;
   endtask
   // Read with polling: up to n tries until masked data matches
   task rchk(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m,
             input int n = 1);
      logic got, ta;
      for (int i = 0; i < n; i++) begin
         @(posedge aclk);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         got = 1'b0;
         while (!got) begin
            @(negedge aclk);
            got = rvalid;
            d = rdata;
            s = rresp;
            ta = arvalid && arready;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
         end
         rready <= 1'b0;
         if ((d & m) === x) break;
      end
      chk(d & m, x);
   endtask
   task count(input int n);
      logic q;
      q = ext_ref_in;
      e = 0;
      p = 0;
      repeat (n) begin
         @(negedge aclk);
         if (ext_ref_in && !q) e++;
         q = ext_ref_in;
         if (ext_ref_clock_out) p++;
      end
   endtask
   function logic ffv(logic [1:0] b, logic [2:0] r);
      return !((b == BUS_DIVIDER_ONE && r < FF_MIN_REFERENCE_DIVIDER_ONE) ||
               (b == BUS_DIVIDER_TWO && r < FF_MIN_REFERENCE_DIVIDER_TWO));
   endfunction
   initial begin
      void'($urandom(32'hd37dd7ca));
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      power_on_resetn <= 1'b1;
      chk(32'(current_mode), 32'(fll_engaged_internal));
      rchk(OFS_CTRL_ONE, 32'(CTRL_ONE_RST), 32'hff);
      rchk(OFS_CTRL_TWO, 32'(CTRL_TWO_RST), 32'hff);
      rchk(OFS_CTRL_THREE, 32'(CTRL_THREE_RST), 32'hff);
      rchk(OFS_STATUS, 32'h10, 32'h1c);
      rchk(OFS_TRIM, 32'(TRIM_RST), 32'hff);
      rchk(8'h18, 32'h0, 32'hffffffff);
      chk(32'(s), 32'(RESP_DECERR));
      repeat (4) begin
         d = $urandom;
         wr(OFS_TRIM, d[7:0]);
         rchk(OFS_TRIM, {24'h0, d[7:0]}, 32'hff);
      end
      wr(OFS_CTRL_TWO, 8'h43);
      stop_request <= 1'b1;
      count(100);
      chk(32'(e >= 9 && p >= e - 1 && p <= e + 1), 32'h1);
      @(posedge aclk);
      stop_request <= 1'b0;
      wr(OFS_CTRL_TWO, 8'h40);
      count(100);
      chk(32'(p), 32'h0);
      wr(OFS_CTRL_ONE, 8'h44);
      rchk(OFS_STATUS, 32'h04, 32'h0c, 200);
      chk(32'(current_mode), 32'(fll_bypassed_internal));
      for (int b = 0; b < 4; b++)
         for (int r = 0; r < 8; r++) begin
            wr(OFS_CTRL_TWO, 8'(b << 6));
            wr(OFS_CTRL_ONE, {2'h1, 3'(r), 3'h4});
            repeat (3) @(posedge aclk);
            chk(32'(fixed_freq_valid), 32'(ffv(2'(b), 3'(r))));
         end
      wr(OFS_CTRL_TWO, 8'h42);
      wr(OFS_CTRL_THREE, 8'h21);
      dead <= 1'b1;
      e = 0;
      while (!loss_reset_request && e < 2000) begin
         @(negedge aclk);
         e++;
      end
      chk(32'(e >= 180 && e < 2000), 32'h1);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(OFS_RST_STATUS, 32'h4, 32'h4);
      rchk(OFS_CTRL_THREE, 32'(CTRL_THREE_RST), 32'hff);
      wr(OFS_RST_STATUS, 8'h04);
      rchk(OFS_RST_STATUS, 32'h0, 32'h4);
      dead <= 1'b0;
      wr(OFS_CTRL_TWO, 8'h46);
      rchk(OFS_STATUS, 32'h02, 32'h02, 4000);
      wr(OFS_CTRL_ONE, 8'h08);
      rchk(OFS_STATUS, 32'h42, 32'h5e, 300);
      chk(32'(current_mode), 32'(fll_engaged_external));
      finish_test;
   end
endmodule
